// ==== eeprom_shadow_access_ctrl.sv ====
// non-volatile parameter memory and shadow copy access controller
//
// Notes on behaviour
// - power-up copies all parameters into shadow
// - shadow word sits 0x40 above its original
// - shadow drops unused bits, reads zero
// - shadow writes need unlock; only lock code 0x3 blocks them
// - reads always allowed, even locked
// - five key bytes written in order unlock
// - unlock persists until power-on reset
// - margin modes need unlocked device
// - lock code 0xc blocks non-volatile writes
// - lock code 0x3 blocks all writes
// - 8-bit write address selects target
// - write data loaded MSB first
// - trigger bit starts whole-word transfer
// - done flag set; slow write bounded
// - shadow write finishes in one cycle
// - done flag at bit 0 of next byte
// - violation ends transfer, sets done, warning
// - aborted non-volatile write sets error bit
// - special 0001 lowers read threshold
// - special 0010 raises read threshold
// - setting applies only after 0xa5 confirm
// - margin codes persist and read back
// - writing 0000 restores normal threshold
`timescale 1ns/100ps
module eeprom_shadow_access_ctrl #(
    parameter int NV_WRITE_CYCLES = eeprom_shadow_pkg::NV_WRITE_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // direct register byte port
    input wire eeprom_shadow_pkg::reg_wr_type reg_wr,
    input wire logic reg_rd_en,
    input wire logic [5:0] reg_rd_addr,
    output logic [7:0] reg_rd_data,
    // non-volatile memory macro
    output eeprom_shadow_pkg::nv_req_type nv_req,
    input wire logic nv_done,
    input wire logic nv_fail,
    input wire logic [31:0] nv_rdata,
    output eeprom_shadow_pkg::margin_type nv_margin,
    // shadow configuration read port
    input wire logic [5:0] cfg_addr,
    output logic [31:0] cfg_data,
    // status and diagnostics
    output logic load_done,
    output logic unlocked,
    output logic xee_warn,
    output logic xee_err,
    input wire logic warn_clear,
    input wire logic err_clear
);
    eeprom_shadow_pkg::state_type state_q;
    eeprom_shadow_pkg::nv_req_type nv_req_q;
    eeprom_shadow_pkg::margin_type margin_q;
    logic [31:0] shadow_mem [eeprom_shadow_pkg::NV_WORDS];
    logic [5:0] load_idx_q;
    logic [3:0] lock_q;
    logic [2:0] key_idx_q;
    logic unlocked_q;
    logic [7:0] wr_addr_q;
    logic [31:0] wr_data_q;
    logic trig_pend_q;
    logic wdn_q;
    logic warn_q;
    logic err_q;
    logic [3:0] special_q;
    logic [31:0] wait_cnt_q;
    logic [31:0] cfg_data_q;
    logic [7:0] rd_data_q;
    logic wr_key;
    logic wr_ctrl;
    logic wr_init;
    logic trig_set;
    logic take;
    logic is_nv;
    logic is_sh;
    logic violate;
    logic viol_ev;
    logic sh_ev;
    logic nv_start;
    logic timeout;
    logic nv_end;
    logic nv_bad;
    logic done_ev;
    logic wip;
    logic confirm;
    // register write decode
    assign wr_key = reg_wr.en && (reg_wr.addr == eeprom_shadow_pkg::OFS_KEY);
    assign wr_ctrl = reg_wr.en && (reg_wr.addr == eeprom_shadow_pkg::OFS_CTRL);
    assign wr_init = reg_wr.en && (reg_wr.addr == eeprom_shadow_pkg::OFS_CTRL_INIT);
    assign trig_set = reg_wr.en && (reg_wr.addr == eeprom_shadow_pkg::OFS_WR_CTRL)
                      && reg_wr.data[eeprom_shadow_pkg::EXW_BIT];
    assign confirm = wr_init && (reg_wr.data == eeprom_shadow_pkg::INITIATE_CODE);
    // a pending trigger is taken only once loading has finished
    assign take = (state_q == eeprom_shadow_pkg::ST_IDLE) && trig_pend_q;
    assign is_nv = (wr_addr_q[7:6] == eeprom_shadow_pkg::REGION_NV);
    assign is_sh = (wr_addr_q[7:6] == eeprom_shadow_pkg::REGION_SHADOW);
    // protection check: unlock, lock codes, unmapped extended address
    always_comb begin
        violate = 1'b0;
        if (!unlocked_q) begin
            violate = 1'b1;
        end else if (!is_nv && !is_sh) begin
            violate = 1'b1;
        end else if (lock_q == eeprom_shadow_pkg::LOCK_ALL) begin
            violate = 1'b1;
        end else if (is_nv && (lock_q == eeprom_shadow_pkg::LOCK_NV_ONLY)) begin
            violate = 1'b1;
        end
    end
    assign viol_ev = take && violate;
    assign sh_ev = take && !violate && is_sh;
    assign nv_start = take && !violate && is_nv;
    assign timeout = (wait_cnt_q >= 32'(NV_WRITE_CYCLES - 1));
    assign nv_end = (state_q == eeprom_shadow_pkg::ST_NV_WAIT) && (nv_done || timeout);
    assign nv_bad = (state_q == eeprom_shadow_pkg::ST_NV_WAIT)
                    && ((nv_done && nv_fail) || (timeout && !nv_done));
    assign done_ev = viol_ev || sh_ev || nv_end;
    assign wip = trig_pend_q || (state_q == eeprom_shadow_pkg::ST_NV_WAIT);
    // sequencer: power-up load, then non-volatile write handling
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= eeprom_shadow_pkg::ST_LOAD_REQ;
            nv_req_q <= '0;
            load_idx_q <= 6'h00;
            lock_q <= eeprom_shadow_pkg::LOCK_RESET;
            wait_cnt_q <= 32'h0000_0000;
        end else begin
            case (state_q)
                eeprom_shadow_pkg::ST_LOAD_REQ: begin
                    nv_req_q <= '{valid: 1'b1, write: 1'b0, addr: load_idx_q,
                                  data: 32'h0000_0000};
                    state_q <= eeprom_shadow_pkg::ST_LOAD_WAIT;
                end
                eeprom_shadow_pkg::ST_LOAD_WAIT: begin
                    if (nv_done) begin
                        nv_req_q <= '0;
                        if (load_idx_q == eeprom_shadow_pkg::LOCK_WORD) begin
                            lock_q <= nv_rdata[eeprom_shadow_pkg::LOCK_LSB +: 4];
                        end
                        if (load_idx_q == 6'(eeprom_shadow_pkg::NV_WORDS - 1)) begin
                            state_q <= eeprom_shadow_pkg::ST_IDLE;
                        end else begin
                            load_idx_q <= load_idx_q + 6'h01;
                            state_q <= eeprom_shadow_pkg::ST_LOAD_REQ;
                        end
                    end
                end
                eeprom_shadow_pkg::ST_IDLE: begin
                    if (nv_start) begin
                        nv_req_q <= '{valid: 1'b1, write: 1'b1, addr: wr_addr_q[5:0],
                                      data: wr_data_q};
                        wait_cnt_q <= 32'h0000_0000;
                        state_q <= eeprom_shadow_pkg::ST_NV_WAIT;
                    end
                end
                eeprom_shadow_pkg::ST_NV_WAIT: begin
                    wait_cnt_q <= wait_cnt_q + 32'h0000_0001;
                    if (nv_end) begin
                        nv_req_q <= '0;
                        state_q <= eeprom_shadow_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_q <= eeprom_shadow_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // shadow copy: loaded at power-up, written by extended shadow writes
    always_ff @(posedge clk_sys) begin
        if (state_q == eeprom_shadow_pkg::ST_LOAD_WAIT && nv_done) begin
            shadow_mem[load_idx_q] <= nv_rdata & eeprom_shadow_pkg::SHADOW_MASK;
        end else if (sh_ev) begin
            shadow_mem[wr_addr_q[5:0]] <= wr_data_q & eeprom_shadow_pkg::SHADOW_MASK;
        end
    end

    // configuration read port for the operating logic
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cfg_data_q <= 32'h0000_0000;
        end else begin
            cfg_data_q <= load_done ? shadow_mem[cfg_addr] : 32'h0000_0000;
        end
    end

    // unlock key sequencer; any wrong byte restarts it
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            key_idx_q <= 3'h0;
            unlocked_q <= 1'b0;
        end else if (wr_key && !unlocked_q) begin
            if (reg_wr.data == eeprom_shadow_pkg::UNLOCK_KEYS[key_idx_q]) begin
                if (key_idx_q == eeprom_shadow_pkg::KEY_LAST) begin
                    unlocked_q <= 1'b1;
                    key_idx_q <= 3'h0;
                end else begin
                    key_idx_q <= key_idx_q + 3'h1;
                end
            end else if (reg_wr.data == eeprom_shadow_pkg::UNLOCK_KEYS[0]) begin
                key_idx_q <= 3'h1;
            end else begin
                key_idx_q <= 3'h0;
            end
        end
    end

    // extended write address and data registers
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wr_addr_q <= 8'h00;
            wr_data_q <= 32'h0000_0000;
        end else if (reg_wr.en) begin
            if (reg_wr.addr == eeprom_shadow_pkg::OFS_WR_ADDR) begin
                wr_addr_q <= reg_wr.data;
            end else if (reg_wr.addr == eeprom_shadow_pkg::OFS_WR_DATA_B3) begin
                wr_data_q[31:24] <= reg_wr.data;
            end else if (reg_wr.addr == eeprom_shadow_pkg::OFS_WR_DATA_B2) begin
                wr_data_q[23:16] <= reg_wr.data;
            end else if (reg_wr.addr == eeprom_shadow_pkg::OFS_WR_DATA_B1) begin
                wr_data_q[15:8] <= reg_wr.data;
            end else if (reg_wr.addr == eeprom_shadow_pkg::OFS_WR_DATA_B0) begin
                wr_data_q[7:0] <= reg_wr.data;
            end
        end
    end

    // trigger pending and done flag; a new trigger beats the take
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            trig_pend_q <= 1'b0;
            wdn_q <= 1'b0;
        end else begin
            trig_pend_q <= trig_set || (trig_pend_q && !take);
            if (done_ev) begin
                wdn_q <= 1'b1;
            end else if (trig_set) begin
                wdn_q <= 1'b0;
            end
        end
    end

    // sticky warning and error bits; set wins over clear
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            warn_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            warn_q <= viol_ev || (warn_q && !warn_clear);
            err_q <= nv_bad || (viol_ev && is_nv) || (err_q && !err_clear);
        end
    end

    // special-function field and read threshold mode
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            special_q <= eeprom_shadow_pkg::SPECIAL_NORMAL;
            margin_q <= eeprom_shadow_pkg::MARGIN_NORMAL;
        end else if (wr_ctrl) begin
            special_q <= reg_wr.data[eeprom_shadow_pkg::SPECIAL_LSB +: 4];
            if (reg_wr.data[eeprom_shadow_pkg::SPECIAL_LSB +: 4]
                    == eeprom_shadow_pkg::SPECIAL_NORMAL) begin
                margin_q <= eeprom_shadow_pkg::MARGIN_NORMAL;
            end
        end else if (confirm) begin
            if (unlocked_q && special_q == eeprom_shadow_pkg::SPECIAL_LOW) begin
                margin_q <= eeprom_shadow_pkg::MARGIN_LOW;
            end else if (unlocked_q && special_q == eeprom_shadow_pkg::SPECIAL_HIGH) begin
                margin_q <= eeprom_shadow_pkg::MARGIN_HIGH;
            end else begin
                margin_q <= eeprom_shadow_pkg::MARGIN_NORMAL;
                special_q <= eeprom_shadow_pkg::SPECIAL_NORMAL;
            end
        end
    end

    // register read: answered one cycle after reg_rd_en
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rd_data_q <= 8'h00;
        end else if (reg_rd_en) begin
            if (reg_rd_addr == eeprom_shadow_pkg::OFS_WR_ADDR) begin
                rd_data_q <= wr_addr_q;
            end else if (reg_rd_addr == eeprom_shadow_pkg::OFS_WR_DATA_B3) begin
                rd_data_q <= wr_data_q[31:24];
            end else if (reg_rd_addr == eeprom_shadow_pkg::OFS_WR_DATA_B2) begin
                rd_data_q <= wr_data_q[23:16];
            end else if (reg_rd_addr == eeprom_shadow_pkg::OFS_WR_DATA_B1) begin
                rd_data_q <= wr_data_q[15:8];
            end else if (reg_rd_addr == eeprom_shadow_pkg::OFS_WR_DATA_B0) begin
                rd_data_q <= wr_data_q[7:0];
            end else if (reg_rd_addr == eeprom_shadow_pkg::OFS_WR_CTRL) begin
                rd_data_q <= {7'h00, wip};
            end else if (reg_rd_addr == eeprom_shadow_pkg::OFS_WR_STAT) begin
                rd_data_q <= {7'h00, wdn_q};
            end else if (reg_rd_addr == eeprom_shadow_pkg::OFS_CTRL) begin
                rd_data_q <= {special_q, 4'h0};
            end else begin
                rd_data_q <= 8'h00;
            end
        end
    end

    assign reg_rd_data = rd_data_q;
    assign nv_req = nv_req_q;
    assign nv_margin = margin_q;
    assign cfg_data = cfg_data_q;
    assign load_done = (state_q == eeprom_shadow_pkg::ST_IDLE)
                       || (state_q == eeprom_shadow_pkg::ST_NV_WAIT);
    assign unlocked = unlocked_q;
    assign xee_warn = warn_q;
    assign xee_err = err_q;

    // checks
    default clocking chk_clk @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    sequence last_key_s;
        reg_wr.en && reg_wr.addr == eeprom_shadow_pkg::OFS_KEY && reg_wr.data == 8'h77;
    endsequence
    sequence confirm_s;
        reg_wr.en && reg_wr.addr == eeprom_shadow_pkg::OFS_CTRL_INIT && reg_wr.data == 8'ha5;
    endsequence
    unlock_key_a: assert property ($rose(unlocked_q) |-> $past(wr_key && reg_wr.data == 8'h77))
        else $error("unlock without final key byte");
    unlock_hold_a: assert property (unlocked_q |=> unlocked_q)
        else $error("unlock state lost");
    shadow_place_a: assert property (sh_ev |=> shadow_mem[$past(wr_addr_q[5:0])] ==
            ($past(wr_data_q) & 32'h00ff_ffff) && wdn_q)
        else $error("shadow write wrong place, value or timing");
    violation_flags_a: assert property (viol_ev |=> wdn_q && warn_q && nv_req_q.valid == 1'b0)
        else $error("violation did not end transfer with flags");
    nv_lock_a: assert property (take && is_nv && lock_q == 4'hc |=> !nv_req_q.write)
        else $error("write reached locked memory");
    all_lock_a: assert property (lock_q == 4'h3 |-> !sh_ev && !nv_start)
        else $error("write accepted under full lock");
    abort_error_a: assert property (nv_bad |=> err_q && wdn_q)
        else $error("aborted write left no error");
    margin_low_a: assert property (confirm_s ##0 (unlocked_q && special_q == 4'h1)
            |=> nv_margin == eeprom_shadow_pkg::MARGIN_LOW ##1
            ($past(wr_ctrl) || nv_margin == eeprom_shadow_pkg::MARGIN_LOW))
        else $error("low threshold not applied");
    margin_high_a: assert property (confirm_s ##0 (unlocked_q && special_q == 4'h2)
            |=> nv_margin == eeprom_shadow_pkg::MARGIN_HIGH)
        else $error("high threshold not applied");
    margin_confirm_a: assert property ($changed(margin_q) && margin_q !=
            eeprom_shadow_pkg::MARGIN_NORMAL |-> $past(confirm && unlocked_q))
        else $error("threshold changed without confirm");
    margin_clear_a: assert property (wr_ctrl && reg_wr.data[7:4] == 4'h0
            |=> nv_margin == eeprom_shadow_pkg::MARGIN_NORMAL)
        else $error("threshold not restored");
    load_first_a: assert property (!load_done |-> !nv_req_q.write)
        else $error("write before load finished");
    unused_zero_a: assert property (cfg_data_q[31:24] == 8'h00)
        else $error("unused shadow bits nonzero");
    last_key_a: assert property (last_key_s ##0 (key_idx_q == 3'h4) |=> unlocked_q)
        else $error("full key sequence did not unlock");
endmodule // eeprom_shadow_access_ctrl

// ==== eeprom_shadow_pkg.sv ====
// constants, types and register map for the non-volatile memory access controller
package eeprom_shadow_pkg;

    // direct register byte offsets
    localparam logic [5:0] OFS_WR_ADDR = 6'h03;
    localparam logic [5:0] OFS_WR_DATA_B3 = 6'h04;
    localparam logic [5:0] OFS_WR_DATA_B2 = 6'h05;
    localparam logic [5:0] OFS_WR_DATA_B1 = 6'h06;
    localparam logic [5:0] OFS_WR_DATA_B0 = 6'h07;
    localparam logic [5:0] OFS_WR_CTRL = 6'h08;
    localparam logic [5:0] OFS_WR_STAT = 6'h09;
    localparam logic [5:0] OFS_CTRL = 6'h1e;
    localparam logic [5:0] OFS_CTRL_INIT = 6'h1f;
    localparam logic [5:0] OFS_KEY = 6'h3c;

    // field positions inside the addressed byte
    localparam int EXW_BIT = 7;
    localparam int WIP_BIT = 0;
    localparam int WDN_BIT = 0;
    localparam int SPECIAL_LSB = 4;

    // extended address map
    localparam int NV_WORDS = 64;
    localparam logic [1:0] REGION_NV = 2'h0;
    localparam logic [1:0] REGION_SHADOW = 2'h1;
    localparam logic [7:0] SHADOW_OFFSET = 8'h40;
    localparam logic [31:0] SHADOW_MASK = 32'h00ff_ffff;

    // lock field location and codes
    localparam logic [5:0] LOCK_WORD = 6'h0b;
    localparam int LOCK_LSB = 20;
    localparam logic [3:0] LOCK_NV_ONLY = 4'hc;
    localparam logic [3:0] LOCK_ALL = 4'h3;
    localparam logic [3:0] LOCK_RESET = 4'h0;

    // unlock key sequence, last entry (index 0) written first
    localparam logic [4:0][7:0] UNLOCK_KEYS = {8'h77, 8'h1f, 8'h81, 8'h27, 8'h00};
    localparam logic [2:0] KEY_LAST = 3'h4;

    // special-function codes
    localparam logic [3:0] SPECIAL_NORMAL = 4'h0;
    localparam logic [3:0] SPECIAL_LOW = 4'h1;
    localparam logic [3:0] SPECIAL_HIGH = 4'h2;
    localparam logic [7:0] INITIATE_CODE = 8'ha5;

    // timing
    localparam int CLK_KHZ = 250000;
    localparam int NV_WRITE_MS = 24;
    localparam int NV_WRITE_CYC = NV_WRITE_MS * CLK_KHZ;

    typedef enum logic [1:0] {
        MARGIN_NORMAL = 2'b00,
        MARGIN_LOW = 2'b01,
        MARGIN_HIGH = 2'b10
    } margin_type;

    typedef enum logic [3:0] {
        ST_LOAD_REQ = 4'b0001,
        ST_LOAD_WAIT = 4'b0010,
        ST_IDLE = 4'b0100,
        ST_NV_WAIT = 4'b1000
    } state_type;

    typedef struct packed {
        logic en;
        logic [5:0] addr;
        logic [7:0] data;
    } reg_wr_type;

    typedef struct packed {
        logic valid;
        logic write;
        logic [5:0] addr;
        logic [31:0] data;
    } nv_req_type;

endpackage

// ==== nv_mem_model.sv ====
// memory macro model answering load reads and word writes
`timescale 1ns/100ps
module nv_mem_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // request side
    input wire eeprom_shadow_pkg::nv_req_type nv_req,
    output logic nv_done,
    output logic nv_fail,
    output logic [31:0] nv_rdata,
    // behaviour control
    input wire logic [3:0] lock_code,
    input wire logic [7:0] delay,
    input wire logic fail_en
);
    logic [31:0] mem [64];
    logic [31:0] rd_q;
    logic [7:0] cnt_q;
    // data lines carry garbage outside the done cycle
    assign nv_rdata = nv_done ? rd_q : ~rd_q;
    // contents re-seeded at each power-up so a run can carry its own lock
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < 64; i++)
                mem[i] <= {8'hfc, (i == 11) ? lock_code : 4'h5, 4'ha, 10'h000, 6'(i)};
            cnt_q <= '0;
            nv_done <= 1'b0;
            nv_fail <= 1'b0;
            rd_q <= '0;
        end else begin
            nv_done <= 1'b0;
            nv_fail <= 1'b0;
            if (!nv_req.valid || nv_done)
                cnt_q <= '0;
            else if (cnt_q < delay)
                cnt_q <= cnt_q + 8'h01;
            else begin
                nv_done <= 1'b1;
                nv_fail <= nv_req.write & fail_en;
                rd_q <= mem[nv_req.addr];
                if (nv_req.write && !fail_en)
                    mem[nv_req.addr] <= nv_req.data;
            end
        end
    end
endmodule // nv_mem_model

// ==== tb.sv ====
// self-checking bench for the parameter memory access controller
`timescale 1ns/100ps
module tb;
    typedef struct packed {
        logic [5:0] addr;
        logic [31:0] exp;
    } row_type;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    eeprom_shadow_pkg::reg_wr_type reg_wr = '0;
    logic reg_rd_en = 1'b0;
    logic [5:0] reg_rd_addr = '0;
    logic [7:0] reg_rd_data;
    eeprom_shadow_pkg::nv_req_type nv_req;
    logic nv_done;
    logic nv_fail;
    logic [31:0] nv_rdata;
    eeprom_shadow_pkg::margin_type nv_margin;
    logic [5:0] cfg_addr = '0;
    logic [31:0] cfg_data;
    logic load_done;
    logic unlocked;
    logic xee_warn;
    logic xee_err;
    logic warn_clear = 1'b0;
    logic err_clear = 1'b0;
    logic [3:0] lock_code = 4'h5;
    logic [7:0] delay = 8'h03;
    logic fail_en = 1'b0;
    int mismatches = 0;
    int checked = 0;
    int cycles = 0;
    logic [7:0] b;
    row_type rows [3] = '{'{6'h00, 32'h005a_0000}, '{6'h0b, 32'h005a_000b},
        '{6'h3f, 32'h005a_003f}};
    logic [7:0] keys [11] = '{8'h00, 8'h27, 8'h81, 8'h55, 8'h1f, 8'h77,
        8'h00, 8'h27, 8'h81, 8'h1f, 8'h77};

    eeprom_shadow_access_ctrl #(.NV_WRITE_CYCLES(50)) u_dut (
        .clk_sys(clk_sys), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd_en(reg_rd_en),
        .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data), .nv_req(nv_req),
        .nv_done(nv_done), .nv_fail(nv_fail), .nv_rdata(nv_rdata), .nv_margin(nv_margin),
        .cfg_addr(cfg_addr), .cfg_data(cfg_data), .load_done(load_done), .unlocked(unlocked),
        .xee_warn(xee_warn), .xee_err(xee_err), .warn_clear(warn_clear), .err_clear(err_clear));
    nv_mem_model u_mem (
        .clk_sys(clk_sys), .reset_n(reset_n), .nv_req(nv_req), .nv_done(nv_done),
        .nv_fail(nv_fail), .nv_rdata(nv_rdata), .lock_code(lock_code), .delay(delay),
        .fail_en(fail_en));

    always #2 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        reg_wr = '{1'b1, a, d};
        @(posedge clk_sys);
        #1 reg_wr.en = 1'b0;
        @(posedge clk_sys);
        #1;
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        reg_rd_en = 1'b1;
        reg_rd_addr = a;
        @(posedge clk_sys);
        #1 reg_rd_en = 1'b0;
        d = reg_rd_data;
        @(posedge clk_sys);
        #1;
    endtask
    task automatic cfg_chk(input logic [5:0] a, input logic [31:0] e);
        cfg_addr = a;
        @(posedge clk_sys);
        #1 chk(cfg_data, e);
    endtask
    task automatic clr();
        warn_clear = 1'b1;
        err_clear = 1'b1;
        @(posedge clk_sys);
        #1 warn_clear = 1'b0;
        err_clear = 1'b0;
    endtask
    task automatic unlock();
        for (int i = 0; i < 11; i++) begin
            if (i == 6)
                chk(32'(unlocked), 32'h0);
            wr(eeprom_shadow_pkg::OFS_KEY, keys[i]);
        end
        chk(32'(unlocked), 32'h1);
    endtask
    task automatic ext_wr(input logic [7:0] a, input logic [31:0] d);
        wr(eeprom_shadow_pkg::OFS_WR_ADDR, a);
        for (int i = 0; i < 4; i++)
            wr(eeprom_shadow_pkg::OFS_WR_DATA_B3 + 6'(i), d[31 - 8 * i -: 8]);
        wr(eeprom_shadow_pkg::OFS_WR_CTRL, 8'h80);
        b = '0;
        for (int i = 0; i < 200 && b[0] !== 1'b1; i++)
            rd(eeprom_shadow_pkg::OFS_WR_STAT, b);
        chk(32'(b[0]), 32'h1);
        rd(eeprom_shadow_pkg::OFS_WR_CTRL, b);
        chk(32'(b), 32'h0);
        rd(eeprom_shadow_pkg::OFS_WR_ADDR, b);
        chk(32'(b), 32'(a));
    endtask
    task automatic power_up(input logic [3:0] lk);
        lock_code = lk;
        reset_n = 1'b0;
        repeat (8) @(posedge clk_sys);
        #1 chk(32'({nv_req.valid, load_done, unlocked, xee_warn, xee_err, nv_margin}), 32'h0);
        reset_n = 1'b1;
        for (int i = 0; i < 2000 && load_done !== 1'b1; i++)
            @(posedge clk_sys);
        #1 chk(32'(load_done), 32'h1);
    endtask

    initial begin
        power_up(4'h5);
        foreach (rows[i])
            cfg_chk(rows[i].addr, rows[i].exp);
        $display("test power_up_load done");
        ext_wr(8'h45, 32'h0000_0001);
        chk({30'h0, xee_warn, xee_err}, 32'h2);
        cfg_chk(6'h05, 32'h005a_0005);
        wr(eeprom_shadow_pkg::OFS_CTRL, 8'h10);
        wr(eeprom_shadow_pkg::OFS_CTRL_INIT, eeprom_shadow_pkg::INITIATE_CODE);
        chk(32'(nv_margin), 32'h0);
        clr();
        chk({30'h0, xee_warn, xee_err}, 32'h0);
        $display("test locked_refusal done");
        unlock();
        for (int m = 1; m < 3; m++) begin
            wr(eeprom_shadow_pkg::OFS_CTRL, 8'(m << 4));
            chk(32'(nv_margin), 32'(m - 1));
            wr(eeprom_shadow_pkg::OFS_CTRL_INIT, eeprom_shadow_pkg::INITIATE_CODE);
            chk(32'(nv_margin), 32'(m));
            rd(eeprom_shadow_pkg::OFS_CTRL, b);
            chk(32'(b[7:4]), 32'(m));
        end
        wr(eeprom_shadow_pkg::OFS_CTRL, 8'h00);
        chk(32'(nv_margin), 32'h0);
        $display("test margin done");
        ext_wr(8'h45, 32'h1234_5678);
        cfg_chk(6'h05, 32'h0034_5678);
        ext_wr(8'h07, 32'hcafe_f00d);
        chk(u_mem.mem[7], 32'hcafe_f00d);
        fail_en = 1'b1;
        ext_wr(8'h09, 32'h0);
        chk({30'h0, xee_warn, xee_err}, 32'h1);
        fail_en = 1'b0;
        clr();
        delay = 8'hff;
        ext_wr(8'h0a, 32'h0);
        chk({30'h0, xee_warn, xee_err}, 32'h1);
        chk(u_mem.mem[10], 32'hfc5a_000a);
        delay = 8'h03;
        clr();
        ext_wr(8'h80, 32'h0);
        chk({30'h0, xee_warn, xee_err}, 32'h2);
        $display("test extended_write done");
        for (int k = 0; k < 2; k++) begin
            power_up(k == 1 ? 4'h3 : 4'hc);
            unlock();
            ext_wr(8'h46, 32'h00ab_cdef);
            cfg_chk(6'h06, k == 1 ? 32'h005a_0006 : 32'h00ab_cdef);
            ext_wr(8'h06, 32'h0);
            chk({30'h0, xee_warn, xee_err}, 32'h3);
            chk(u_mem.mem[6], 32'hfc5a_0006);
        end
        $display("test lock_codes done");
        stop_test();
    end
endmodule // tb
